/* serial_pin_pkg.sv */
// constants for the serial pin port and overrun status block
package serial_pin_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] PORT_CTRL_OFS = 12'h000;
  localparam logic [11:0] LINE_STATUS_OFS = 12'h004;
  localparam logic [11:0] ENABLES_OFS = 12'h008;
  localparam int DEC_W = 12;

  // ==========================================================
  // port control fields
  localparam int RTS_DIR_BIT = 7;
  localparam int RTS_DATA_BIT = 6;
  localparam int CTS_DIR_BIT = 5;
  localparam int CTS_DATA_BIT = 4;
  localparam int BRK_DIR_BIT = 1;
  localparam int BRK_DATA_BIT = 0;

  // line status and enable fields
  localparam int OVERRUN_BIT = 0;
  localparam int TE_BIT = 0;
  localparam int RE_BIT = 1;
  localparam int MCE_BIT = 3;

  // ==========================================================
  // reset values and levels
  localparam logic CTRL_RESET = 1'b0;
  localparam logic MODEM_OFF_LEVEL = 1'b0;
  localparam logic SYNC_RESET = 1'b0;

  // ==========================================================
  // receive fifo
  localparam int RX_COUNT_W = 5;
  localparam logic [RX_COUNT_W-1:0] RX_FIFO_FULL = 5'h10;

  // ==========================================================
  // axi4-lite
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);
  import serial_pin_pkg::*;

  initial begin
    if (WIDTH < 1) $error("pin_sync3: WIDTH must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1, s2, s3, lvl;
      logic next_lvl;
      // first stage is read only by the second
      always_comb begin
        next_lvl = (s2 == s3) ? s3 : lvl;
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1 <= SYNC_RESET;
          s2 <= SYNC_RESET;
          s3 <= SYNC_RESET;
          lvl <= SYNC_RESET;
        end else if (ce) begin
          s1 <= async_in[i];
          s2 <= s1;
          s3 <= s2;
          lvl <= next_lvl;
        end
      end
      assign level[i] = lvl;
    end
  endgenerate
endmodule // pin_sync3
`default_nettype wire

/* serial_pin_port.sv */
// serial pin port control and receive overrun status, axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
module serial_pin_port #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [serial_pin_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [serial_pin_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [serial_pin_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic request_to_send_pin_in,
  output logic request_to_send_pin_out,
  output logic request_to_send_pin_oe_n,
  input wire logic clear_to_send_pin_in,
  output logic clear_to_send_pin_out,
  output logic clear_to_send_pin_oe_n,
  output logic transmit_data_pin,
  input wire logic receive_data_pin,
  // frame engine side
  input wire logic tx_serial_level,
  input wire logic rts_handshake_level,
  output logic cts_handshake_level,
  input wire logic rx_char_done,
  input wire logic [serial_pin_pkg::RX_COUNT_W-1:0] rx_fifo_count,
  output logic rx_char_accept,
  output logic transmit_enable_bit,
  output logic receive_enable_bit,
  output logic modem_control_enable
);
  import serial_pin_pkg::*;

  initial if (ADDR_W < DEC_W) $error("ADDR_W below decode width");

  // ==========================================================
  // control state
  logic rts_port_direction, rts_port_data;
  logic cts_port_direction, cts_port_data;
  logic break_port_direction, break_port_data;
  logic overrun_flag, overrun_read_seen, next_overrun, next_read_seen;
  logic next_rts_dir, next_rts_data, next_cts_dir, next_cts_data;
  logic next_brk_dir, next_brk_data, next_te, next_re, next_mce;

  // pin drive registers
  logic next_rts_out, next_rts_oe_n, next_cts_out, next_cts_oe_n;
  logic next_txd, next_cts_hs;

  // bus state
  logic aw_held, w_held;
  logic [DEC_W-1:0] wr_addr, next_wr_addr;
  logic [DATA_W-1:0] wr_data, next_wr_data, next_rdata;
  logic [DATA_W/8-1:0] wr_strb, next_wr_strb;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  logic do_write, rd_take, wr_port, wr_status, wr_enables;
  logic ovr_set, ovr_clear, rd_status_hit;
  logic [2:0] pin_level;
  logic rts_level, cts_level, rxd_level;
  logic [DEC_W-1:0] rd_addr;

  // ==========================================================
  // pin synchronisers
  pin_sync3 #(.WIDTH(3)) u_sync (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .async_in({request_to_send_pin_in, clear_to_send_pin_in,
               receive_data_pin}),
    .level(pin_level));
  assign rts_level = pin_level[2];
  assign cts_level = pin_level[1];
  assign rxd_level = pin_level[0];

  // ==========================================================
  // axi4-lite handshakes
  // ready gated by ce so nothing is taken while frozen
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr[DEC_W-1:0];
  assign wr_port = do_write && wr_addr == PORT_CTRL_OFS && wr_strb[0];
  assign wr_status = do_write && wr_addr == LINE_STATUS_OFS && wr_strb[0];
  assign wr_enables = do_write && wr_addr == ENABLES_OFS && wr_strb[0];
  assign rd_status_hit = rd_take && rd_addr == LINE_STATUS_OFS;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr[DEC_W-1:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (wr_addr)
        PORT_CTRL_OFS, LINE_STATUS_OFS, ENABLES_OFS: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      case (rd_addr)
        PORT_CTRL_OFS: begin
          next_rdata[RTS_DIR_BIT] = rts_port_direction;
          next_rdata[RTS_DATA_BIT] = rts_level;
          next_rdata[CTS_DIR_BIT] = cts_port_direction;
          next_rdata[CTS_DATA_BIT] = cts_level;
          next_rdata[BRK_DIR_BIT] = break_port_direction;
          next_rdata[BRK_DATA_BIT] = rxd_level;
        end
        LINE_STATUS_OFS: next_rdata[OVERRUN_BIT] = overrun_flag;
        ENABLES_OFS: begin
          next_rdata[TE_BIT] = transmit_enable_bit;
          next_rdata[RE_BIT] = receive_enable_bit;
          next_rdata[MCE_BIT] = modem_control_enable;
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ==========================================================
  // port control register, writable at any time
  always_comb begin
    next_rts_dir = rts_port_direction;
    next_rts_data = rts_port_data;
    next_cts_dir = cts_port_direction;
    next_cts_data = cts_port_data;
    next_brk_dir = break_port_direction;
    next_brk_data = break_port_data;
    next_te = transmit_enable_bit;
    next_re = receive_enable_bit;
    next_mce = modem_control_enable;
    if (wr_port) begin
      next_rts_dir = wr_data[RTS_DIR_BIT];
      next_rts_data = wr_data[RTS_DATA_BIT];
      next_cts_dir = wr_data[CTS_DIR_BIT];
      next_cts_data = wr_data[CTS_DATA_BIT];
      next_brk_dir = wr_data[BRK_DIR_BIT];
      next_brk_data = wr_data[BRK_DATA_BIT];
    end
    if (wr_enables) begin
      next_te = wr_data[TE_BIT];
      next_re = wr_data[RE_BIT];
      next_mce = wr_data[MCE_BIT];
    end
  end

  // ==========================================================
  // pin drive, computed from next state so pins follow writes at once
  always_comb begin
    next_rts_oe_n = 1'b0;
    next_cts_oe_n = !next_cts_dir;
    next_cts_out = next_cts_data;
    if (next_rts_dir) begin
      next_rts_out = next_rts_data;
    end else if (next_mce) begin
      next_rts_out = rts_handshake_level;
    end else begin
      next_rts_out = MODEM_OFF_LEVEL;
    end
    // port data only when direction set, otherwise transmitter owns txd
    next_txd = next_brk_dir ? next_brk_data : tx_serial_level;
    // with handshake off the cts input reads as MODEM_OFF_LEVEL (low), not the pin
    next_cts_hs = next_mce ? cts_level : MODEM_OFF_LEVEL;
  end

  // ==========================================================
  // overrun flag
  // the clear needs a prior read of 1, so a stale 0 write cannot drop it
  assign ovr_set = rx_char_done && receive_enable_bit
                   && rx_fifo_count == RX_FIFO_FULL;
  assign ovr_clear = wr_status && !wr_data[OVERRUN_BIT]
                     && overrun_read_seen;
  // full fifo or pending overrun: character is dropped
  assign rx_char_accept = ce && rx_char_done && receive_enable_bit
                          && !overrun_flag
                          && rx_fifo_count != RX_FIFO_FULL;

  always_comb begin
    // set wins over clear; receive enable plays no part in clearing
    next_overrun = ovr_set || (overrun_flag && !ovr_clear);
    next_read_seen = next_overrun && !ovr_clear
                     && (overrun_read_seen || (rd_status_hit && overrun_flag));
  end

  // ==========================================================
  // registers; only reset clears them, standby has no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_port_direction <= CTRL_RESET;
      rts_port_data <= CTRL_RESET;
      cts_port_direction <= CTRL_RESET;
      cts_port_data <= CTRL_RESET;
      break_port_direction <= CTRL_RESET;
      break_port_data <= CTRL_RESET;
      transmit_enable_bit <= CTRL_RESET;
      receive_enable_bit <= CTRL_RESET;
      modem_control_enable <= CTRL_RESET;
      overrun_flag <= CTRL_RESET;
      overrun_read_seen <= CTRL_RESET;
      request_to_send_pin_out <= MODEM_OFF_LEVEL;
      request_to_send_pin_oe_n <= 1'b0;
      clear_to_send_pin_out <= CTRL_RESET;
      clear_to_send_pin_oe_n <= 1'b1;
      transmit_data_pin <= 1'b1;
      cts_handshake_level <= MODEM_OFF_LEVEL;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      rts_port_direction <= next_rts_dir;
      rts_port_data <= next_rts_data;
      cts_port_direction <= next_cts_dir;
      cts_port_data <= next_cts_data;
      break_port_direction <= next_brk_dir;
      break_port_data <= next_brk_data;
      transmit_enable_bit <= next_te;
      receive_enable_bit <= next_re;
      modem_control_enable <= next_mce;
      overrun_flag <= next_overrun;
      overrun_read_seen <= next_read_seen;
      request_to_send_pin_out <= next_rts_out;
      request_to_send_pin_oe_n <= next_rts_oe_n;
      clear_to_send_pin_out <= next_cts_out;
      clear_to_send_pin_oe_n <= next_cts_oe_n;
      transmit_data_pin <= next_txd;
      cts_handshake_level <= next_cts_hs;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rts_drive_a: assert property (
    rts_port_direction |->
      request_to_send_pin_out == rts_port_data && !request_to_send_pin_oe_n)
    else $error("rts pin does not carry port data");
  cts_drive_a: assert property (
    (cts_port_direction |-> clear_to_send_pin_out == cts_port_data
       && !clear_to_send_pin_oe_n)
    and (!cts_port_direction |-> clear_to_send_pin_oe_n))
    else $error("cts pin drive wrong");
  break_drive_a: assert property (
    break_port_direction |-> transmit_data_pin == break_port_data)
    else $error("txd does not carry break data");
  tx_pass_a: assert property (
    ce && !next_brk_dir |=> transmit_data_pin == $past(tx_serial_level))
    else $error("txd not handed to transmitter");
  overrun_set_a: assert property (
    ce && rx_char_done && receive_enable_bit
      && rx_fifo_count == RX_FIFO_FULL |=> overrun_flag)
    else $error("overrun not flagged");
  discard_new_a: assert property (
    rx_char_accept |-> rx_fifo_count != RX_FIFO_FULL)
    else $error("character accepted into full fifo");
  halt_receive_a: assert property (
    overrun_flag |-> !rx_char_accept)
    else $error("reception continued during overrun");
  overrun_hold_a: assert property (
    overrun_flag && !(ce && wr_status && overrun_read_seen)
      |=> overrun_flag)
    else $error("overrun flag lost without a clear");
  clear_needs_read_a: assert property (
    overrun_flag && ce && wr_status && !wr_data[OVERRUN_BIT]
      && !overrun_read_seen |=> overrun_flag)
    else $error("overrun cleared without prior read");
  reserved_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[DATA_W-1:8] == '0)
    else $error("reserved bits not zero");
  reset_clear_a: assert property (
    $past(!aresetn) |-> !rts_port_direction && !cts_port_direction
      && !break_port_direction && !overrun_flag)
    else $error("control bits not cleared by reset");
  pin_read_a: assert property (
    ce && rd_take && rd_addr == PORT_CTRL_OFS
      |=> s_axi_rdata[BRK_DATA_BIT] == $past(rxd_level))
    else $error("break data read is not rxd level");
endmodule // serial_pin_port
`default_nettype wire

/* serial_peer.sv */
// far-end serial peer: drives cts and rxd, watches rts
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic aclk,
  input wire logic ready,
  input wire logic line,
  input wire logic rts_seen,
  output logic cts_drv,
  output logic rxd_drv,
  output logic rts_last
);
  // =====
  // lines
  // peer registers its lines, so it answers a cycle late
  always_ff @(posedge aclk) begin
    cts_drv <= ready;
    rxd_drv <= line;
    rts_last <= rts_seen;
  end
endmodule // serial_peer
`default_nettype wire

/* serial_pin_port_tb.sv */
// self-checking bench for the serial pin port block
`timescale 1ns/100ps
`default_nettype none
module serial_pin_port_tb;
  import serial_pin_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic request_to_send_pin_in, request_to_send_pin_out;
  logic request_to_send_pin_oe_n, clear_to_send_pin_in;
  logic clear_to_send_pin_out, clear_to_send_pin_oe_n;
  logic transmit_data_pin, receive_data_pin;
  logic tx_serial_level = 1, rts_handshake_level = 0;
  logic cts_handshake_level, rx_char_done = 0, rx_char_accept;
  logic [4:0] rx_fifo_count = 0;
  logic transmit_enable_bit, receive_enable_bit, modem_control_enable;
  logic peer_ready = 0, peer_line = 1, cts_drv, rts_last;
  logic [7:0] v = 8'h5d;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0, checked = 0;

  // =====
  // wires and instances
  // a released rts line shows the inverse of its output; a released cts line shows the peer's cts_drv
  assign request_to_send_pin_in = request_to_send_pin_oe_n ?
      ~request_to_send_pin_out : request_to_send_pin_out;
  assign clear_to_send_pin_in = clear_to_send_pin_oe_n ?
      cts_drv : clear_to_send_pin_out;

  serial_pin_port dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .request_to_send_pin_in, .request_to_send_pin_out,
    .request_to_send_pin_oe_n, .clear_to_send_pin_in,
    .clear_to_send_pin_out, .clear_to_send_pin_oe_n,
    .transmit_data_pin, .receive_data_pin, .tx_serial_level,
    .rts_handshake_level, .cts_handshake_level, .rx_char_done,
    .rx_fifo_count, .rx_char_accept, .transmit_enable_bit,
    .receive_enable_bit, .modem_control_enable);

  serial_peer peer (.aclk, .ready(peer_ready), .line(peer_line),
    .rts_seen(request_to_send_pin_out), .cts_drv,
    .rxd_drv(receive_data_pin), .rts_last);

  initial begin
    forever #50 aclk = ~aclk;
  end

  // =====
  // checking
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk_bus(string nm, logic [33:0] e, logic [33:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk_bus("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk_bus("bresp", bq.pop_front(), s_axi_bresp);
  end

  // =====
  // bus master
  task automatic tmo;
    n_mismatch++;
    give_verdict();
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    int n;
    logic ta, tw;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) break;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    if (n == 40) tmo();
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r);
    int n;
    logic ta;
    rq.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) break;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end
    if (n == 40) tmo();
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask

  // =====
  // stimulus helpers
  task automatic pins(logic r, logic c, logic oe, logic t);
    repeat (6) @(posedge aclk);
    chk_pin("rts", r, request_to_send_pin_out);
    chk_pin("rts_peer", r, rts_last);
    chk_pin("cts", c, clear_to_send_pin_in);
    chk_pin("cts_oe_n", oe, clear_to_send_pin_oe_n);
    chk_pin("txd", t, transmit_data_pin);
  endtask

  task automatic pulse(logic [4:0] c, logic e);
    @(posedge aclk);
    rx_char_done <= 1;
    rx_fifo_count <= c;
    @(negedge aclk);
    chk_pin("accept", e, rx_char_accept);
    @(posedge aclk);
    rx_char_done <= 0;
  endtask

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // =====
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (6) @(posedge aclk);
    rd(PORT_CTRL_OFS, 32'h01, RESP_OKAY);
    rd(LINE_STATUS_OFS, 32'h0, RESP_OKAY);
    wr(12'h00c, 32'h1, RESP_SLVERR);
    rd(12'h00c, 32'h0, RESP_SLVERR);
    $display("test reset done");
    // modem and transmit enables stay 0 for port output use
    wr(PORT_CTRL_OFS, 32'hf3, RESP_OKAY);
    pins(1, 1, 0, 1);
    rd(PORT_CTRL_OFS, 32'hf3, RESP_OKAY);
    wr(PORT_CTRL_OFS, 32'ha2, RESP_OKAY);
    pins(0, 0, 0, 0);
    rd(PORT_CTRL_OFS, 32'ha3, RESP_OKAY);
    peer_ready <= 1;
    peer_line <= 0;
    tx_serial_level <= 0;
    wr(PORT_CTRL_OFS, 32'h0, RESP_OKAY);
    pins(0, 1, 1, 0);
    rd(PORT_CTRL_OFS, 32'h10, RESP_OKAY);
    $display("test port pins done");
    repeat (4) begin
      v = lfsr(v);
      wr(PORT_CTRL_OFS, {24'h0, v & 8'h51 | 8'ha2}, RESP_OKAY);
      pins(v[6], v[4], 0, v[0]);
      rd(PORT_CTRL_OFS, {24'h0, v & 8'h50 | 8'ha2}, RESP_OKAY);
    end
    $display("test random levels done");
    rts_handshake_level <= 1;
    wr(PORT_CTRL_OFS, 32'h0, RESP_OKAY);
    wr(ENABLES_OFS, 32'h9, RESP_OKAY);
    pins(1, 1, 1, 0);
    chk_pin("cts_hs", 1, cts_handshake_level);
    rd(ENABLES_OFS, 32'h9, RESP_OKAY);
    chk_pin("mce", 1, modem_control_enable);
    chk_pin("te", 1, transmit_enable_bit);
    wr(ENABLES_OFS, 32'h0, RESP_OKAY);
    pins(0, 1, 1, 0);
    chk_pin("cts_hs", 0, cts_handshake_level);
    $display("test modem done");
    wr(PORT_CTRL_OFS, 32'ha2, RESP_OKAY);
    @(posedge aclk);
    ce <= 0;
    repeat (8) @(posedge aclk);
    ce <= 1;
    pins(0, 0, 0, 0);
    s_axi_wstrb <= 4'he;
    wr(PORT_CTRL_OFS, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(PORT_CTRL_OFS, 32'ha2, RESP_OKAY);
    peer_ready <= 0;
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    pins(0, 0, 1, 0);
    rd(PORT_CTRL_OFS, 32'h0, RESP_OKAY);
    $display("test standby and reset done");
    wr(ENABLES_OFS, 32'h2, RESP_OKAY);
    chk_pin("re", 1, receive_enable_bit);
    pulse(5'h05, 1);
    pulse(5'h10, 0);
    wr(LINE_STATUS_OFS, 32'h0, RESP_OKAY);
    rd(LINE_STATUS_OFS, 32'h1, RESP_OKAY);
    pulse(5'h03, 0);
    wr(ENABLES_OFS, 32'h0, RESP_OKAY);
    chk_pin("re", 0, receive_enable_bit);
    rd(LINE_STATUS_OFS, 32'h1, RESP_OKAY);
    wr(LINE_STATUS_OFS, 32'h1, RESP_OKAY);
    rd(LINE_STATUS_OFS, 32'h1, RESP_OKAY);
    wr(LINE_STATUS_OFS, 32'h0, RESP_OKAY);
    rd(LINE_STATUS_OFS, 32'h0, RESP_OKAY);
    wr(ENABLES_OFS, 32'h2, RESP_OKAY);
    pulse(5'h03, 1);
    $display("test overrun done");
    give_verdict();
  end
endmodule // serial_pin_port_tb
`default_nettype wire
